// ---- src/blk_lock_defs.vh ----
// Constants for the per-block lock controller of a serial flash.
// Assumes inclusion by bare name from the controller module.
// Notes on behaviour
// - Block lock bits gate program/erase only when scheme select is set; else range protection.
// - All lock bits come up as 1 after reset.
// - Opcode 36h plus 24-bit address locks block at chip-select rise, clears write enable.
// - Opcode 39h plus 24-bit address unlocks block at chip-select rise, clears write enable.
// - Opcodes 3Ch and 3Dh both read lock status identically.
// - After address, one status byte shifts out MSB first; bit 0 is lock bit.
// - Status bit 0 high means locked, low means unlocked.
// - Program or erase into a locked block is refused while block scheme is active.
// - Status byte repeats every eight clocks until chip select rises.
// - Reported lock bit belongs to the 4 kB region holding the address.
// - Opcode 7Eh sets every lock bit at chip-select rise and clears write enable.
// - Write enable, lock, unlock, global lock abort if bit count not multiple of eight.
// - Lock and unlock have no data phase; status read returns data on serial output.
// - Commands needing write enable are ignored when the latch is clear.
// - Opcode 06h sets the write enable latch at chip-select rise.
`ifndef BLK_LOCK_DEFS_VH
`define BLK_LOCK_DEFS_VH
`define OP_WREN        8'h06
`define OP_VOL_WREN    8'h50
`define OP_BLK_LOCK    8'h36
`define OP_BLK_UNLOCK  8'h39
`define OP_RD_LOCK_A   8'h3C
`define OP_RD_LOCK_B   8'h3D
`define OP_GLOBAL_LOCK 8'h7E
`define ADDR_BITS      24
`define BLK_SHIFT      12
`define CMD_BITS       6'h08
`define CMD_ADDR_BITS  6'h20
`define LOCK_RESET     1'b1
`endif

// ---- src/blk_lock_ctrl.v ----
// Per-block write-protection controller: serial command decode and lock store.
// Assumes serial pins arrive asynchronously; clock must run well above twice serial clock.
`timescale 1ns/1ps
`default_nettype none
`include "blk_lock_defs.vh"
module blk_lock_ctrl #(
	parameter NUM_BLOCKS = 256,
	parameter BLK_W      = 8
) (
	// Clock and reset
	input  wire             i_clk,
	input  wire             i_srst,
	// Serial pins
	input  wire             i_sck,
	input  wire             i_cs_n,
	input  wire             i_si,
	output reg              o_so,
	output reg              o_so_oe_n,
	// Configuration
	input  wire             i_protect_scheme_select,
	input  wire             i_range_protected,
	// Program and erase gating
	input  wire             i_pe_req,
	input  wire [23:0]      i_pe_addr,
	output reg              o_pe_allow,
	// Status
	output reg              o_write_enable_latch
);
	// Synchronisers
	reg [1:0] sck_sync_reg;
	reg [1:0] cs_sync_reg;
	reg [1:0] si_sync_reg;
	reg       sck_prev_reg;
	reg       cs_prev_reg;
	always @(posedge i_clk) begin
		if (i_srst) begin
			sck_sync_reg <= 2'h0;
			cs_sync_reg  <= 2'h3;
			si_sync_reg  <= 2'h0;
			sck_prev_reg <= 1'b0;
			cs_prev_reg  <= 1'b1;
		end else begin
			sck_sync_reg <= {sck_sync_reg[0], i_sck};
			cs_sync_reg  <= {cs_sync_reg[0], i_cs_n};
			si_sync_reg  <= {si_sync_reg[0], i_si};
			sck_prev_reg <= sck_sync_reg[1];
			cs_prev_reg  <= cs_sync_reg[1];
		end
	end
	wire sck_s   = sck_sync_reg[1];
	wire cs_s    = cs_sync_reg[1];
	wire sck_ris = sck_s & ~sck_prev_reg & ~cs_s;
	wire sck_fal = ~sck_s & sck_prev_reg & ~cs_s;
	wire cs_rise = cs_s & ~cs_prev_reg;
	wire cs_fall = ~cs_s & cs_prev_reg;

	function is_read_op;
		input [7:0] op;
		begin
			is_read_op = (op == `OP_RD_LOCK_A) || (op == `OP_RD_LOCK_B);
		end
	endfunction

	function [BLK_W-1:0] blk_of;
		input [23:0] addr;
		begin
			blk_of = addr[`BLK_SHIFT +: BLK_W];
		end
	endfunction

	reg [NUM_BLOCKS-1:0] lock_reg;
	reg [5:0]            bits_reg;
	reg                  bits_ovf_reg;
	reg [7:0]            op_reg;
	reg [23:0]           addr_reg;
	reg [7:0]            out_byte_reg;
	reg [2:0]            out_cnt_reg;
	reg                  reading_reg;
	reg                  armed_reg;

	wire       byte_aligned = (bits_reg[2:0] == 3'h0);
	wire       op_only      = ~bits_ovf_reg && (bits_reg == `CMD_BITS);
	wire       op_addr      = ~bits_ovf_reg && (bits_reg == `CMD_ADDR_BITS);
	wire       addr_done    = bits_ovf_reg || (bits_reg >= `CMD_ADDR_BITS);
	wire [BLK_W-1:0] cmd_blk = blk_of(addr_reg);

	// Command shift and execute
	always @(posedge i_clk) begin
		if (i_srst) begin
			lock_reg             <= {NUM_BLOCKS{`LOCK_RESET}};
			bits_reg             <= 6'h00;
			bits_ovf_reg         <= 1'b0;
			op_reg               <= 8'h00;
			addr_reg             <= 24'h000000;
			o_write_enable_latch <= 1'b0;
			reading_reg          <= 1'b0;
			armed_reg            <= 1'b0;
		end else begin
			if (cs_fall) begin
				bits_reg     <= 6'h00;
				bits_ovf_reg <= 1'b0;
				reading_reg  <= 1'b0;
				armed_reg    <= 1'b1;
			end else if (sck_ris && armed_reg) begin
				if (bits_reg < `CMD_BITS)
					op_reg <= {op_reg[6:0], si_sync_reg[1]};
				else if (bits_reg < `CMD_ADDR_BITS)
					addr_reg <= {addr_reg[22:0], si_sync_reg[1]};
				if (bits_reg == 6'h3F)
					bits_ovf_reg <= 1'b1;
				bits_reg <= bits_reg + 6'h01;
				if (bits_reg == `CMD_ADDR_BITS - 6'h01 && is_read_op(op_reg))
					reading_reg <= 1'b1;
			end
			if (cs_rise && armed_reg) begin
				armed_reg   <= 1'b0;
				reading_reg <= 1'b0;
				if (byte_aligned) begin
					if (op_only && op_reg == `OP_WREN)
						o_write_enable_latch <= 1'b1;
					else if (op_only && op_reg == `OP_GLOBAL_LOCK && o_write_enable_latch) begin
						lock_reg             <= {NUM_BLOCKS{1'b1}};
						o_write_enable_latch <= 1'b0;
					end else if (op_addr && op_reg == `OP_BLK_LOCK && o_write_enable_latch) begin
						lock_reg[cmd_blk]    <= 1'b1;
						o_write_enable_latch <= 1'b0;
					end else if (op_addr && op_reg == `OP_BLK_UNLOCK && o_write_enable_latch) begin
						lock_reg[cmd_blk]    <= 1'b0;
						o_write_enable_latch <= 1'b0;
					end
				end
			end
		end
	end

	// Status byte output, changed on falling serial clock
	always @(posedge i_clk) begin
		if (i_srst) begin
			o_so         <= 1'b0;
			o_so_oe_n    <= 1'b1;
			out_byte_reg <= 8'h00;
			out_cnt_reg  <= 3'h0;
		end else if (cs_s) begin
			o_so_oe_n   <= 1'b1;
			out_cnt_reg <= 3'h0;
		end else if (sck_fal && reading_reg && addr_done) begin
			o_so_oe_n <= 1'b0;
			if (out_cnt_reg == 3'h0) begin
				out_byte_reg <= {7'h00, lock_reg[cmd_blk]};
				o_so         <= 1'b0;
			end else begin
				o_so <= out_byte_reg[3'h7 - out_cnt_reg];
			end
			out_cnt_reg <= out_cnt_reg + 3'h1;
		end
	end

	// Program and erase gate
	always @(posedge i_clk) begin
		if (i_srst)
			o_pe_allow <= 1'b0;
		else if (i_protect_scheme_select)
			o_pe_allow <= i_pe_req & ~lock_reg[blk_of(i_pe_addr)];
		else
			o_pe_allow <= i_pe_req & ~i_range_protected;
	end
endmodule
`default_nettype wire

// ---- tb/blk_lock_checker.sv ----
// Port assertions for the block lock controller.
// Bound to every blk_lock_ctrl instance.
`timescale 1ns/1ps
`default_nettype none
module blk_lock_checker (
	input wire logic        i_clk, i_srst, i_sck, i_cs_n, i_si, o_so, o_so_oe_n,
	input wire logic        i_protect_scheme_select, i_range_protected, i_pe_req,
	input wire logic [23:0] i_pe_addr,
	input wire logic        o_pe_allow, o_write_enable_latch
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_srst);
	a_oe_release: assert property ($rose(i_cs_n) |-> ##[1:5] o_so_oe_n) else $error("oe stuck");
	a_oe_byte: assert property ($fell(o_so_oe_n) |-> !o_so_oe_n [*8]) else $error("oe short");
	a_oe_select: assert property ($fell(o_so_oe_n) |-> !i_cs_n) else $error("oe unselected");
	a_so_edge: assert property ($changed(o_so) |-> i_cs_n || !$past(i_sck, 2)) else $error("so edge");
	a_pe_req: assert property (!i_pe_req |=> !o_pe_allow) else $error("allow without req");
	a_pe_range: assert property (!i_protect_scheme_select && i_pe_req |=>
		o_pe_allow == !$past(i_range_protected)) else $error("range gate");
	a_wel_rise: assert property ($rose(o_write_enable_latch) |-> i_cs_n) else $error("wel set");
	a_wel_fall: assert property ($fell(o_write_enable_latch) |-> i_cs_n) else $error("wel clear");
	c_wel: cover property ($rose(o_write_enable_latch));
	c_read: cover property ($fell(o_so_oe_n));
	c_allow: cover property (o_pe_allow);
endmodule
bind blk_lock_ctrl blk_lock_checker u_blk_lock_checker (.*);
`default_nettype wire

// ---- tb/spi_host_model.sv ----
// Host side of the serial link, mode 0, one frame per call.
// Frames start off the system clock grid.
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
	input  wire logic i_so,
	output var logic  o_sck, o_cs_n, o_si
);
	initial begin
		o_sck = 1'h0;
		o_cs_n = 1'h1;
		o_si = 1'h0;
	end
	task automatic xfer(input logic [47:0] d, input int n, output logic [15:0] rx);
		rx = 16'h0000;
		#13 o_cs_n = 1'h0;
		for (int i = 0; i < n; i++) begin
			o_si = d[47 - i];
			#200 o_sck = 1'h1;
			// Device output lags the pin by its sync delay
			#100 rx = {rx[14:0], i_so};
			#100 o_sck = 1'h0;
		end
		#200 o_cs_n = 1'h1;
		o_si = ~o_si;
		#800;
	endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for blk_lock_ctrl.
// Host model drives the serial pins; bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        i_clk = 1'h0, i_srst = 1'h1, i_protect_scheme_select = 1'h1, i_range_protected = 1'h0;
	logic        i_pe_req = 1'h0;
	logic [23:0] i_pe_addr = 24'h000000;
	logic [15:0] rx;
	wire         i_sck, i_cs_n, i_si, o_so, o_so_oe_n, o_pe_allow, o_write_enable_latch;
	wire         so_w = o_so_oe_n ? ~o_so : o_so;
	int          err_total = 0, n_checks = 0, cyc = 0;
	always #25 i_clk = ~i_clk;
	blk_lock_ctrl u_blk_lock_ctrl (
		.i_clk                   (i_clk),
		.i_srst                  (i_srst),
		.i_sck                   (i_sck),
		.i_cs_n                  (i_cs_n),
		.i_si                    (i_si),
		.o_so                    (o_so),
		.o_so_oe_n               (o_so_oe_n),
		.i_protect_scheme_select (i_protect_scheme_select),
		.i_range_protected       (i_range_protected),
		.i_pe_req                (i_pe_req),
		.i_pe_addr               (i_pe_addr),
		.o_pe_allow              (o_pe_allow),
		.o_write_enable_latch    (o_write_enable_latch)
	);
	spi_host_model u_spi_host_model (.i_so(so_w), .o_sck(i_sck), .o_cs_n(i_cs_n), .o_si(i_si));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic cmd(input logic [31:0] oa, input int n);
		u_spi_host_model.xfer({oa, 16'h0000}, n, rx);
	endtask
	task automatic rd(input logic [31:0] oa, input logic e);
		u_spi_host_model.xfer({oa, 16'h0000}, 48, rx);
		chk({6'h00, rx[8], rx[0]}, {6'h00, e, e});
	endtask
	task automatic pe(input logic [23:0] a, input logic e);
		@(posedge i_clk);
		i_pe_req <= 1'h1;
		i_pe_addr <= a;
		repeat (3) @(posedge i_clk);
		chk({7'h00, o_pe_allow}, {7'h00, e});
		i_pe_req <= 1'h0;
	endtask
	task automatic write_enable_latch(input logic e);
		chk({7'h00, o_write_enable_latch}, {7'h00, e});
	endtask
	task automatic s_reset_state();
		rd(32'h3C012345, 1'h1);
		pe(24'h012000, 1'h0);
	endtask
	task automatic s_lock_unlock();
		cmd(32'h39012345, 32);
		rd(32'h3C012345, 1'h1);
		cmd(32'h06000000, 8);
		write_enable_latch(1'h1);
		cmd(32'h39012345, 32);
		write_enable_latch(1'h0);
		rd(32'h3D012FFF, 1'h0);
		rd(32'h3C013000, 1'h1);
		pe(24'h012ABC, 1'h1);
		pe(24'h011FFF, 1'h0);
		cmd(32'h06000000, 8);
		cmd(32'h36012000, 32);
		rd(32'h3C012000, 1'h1);
	endtask
	task automatic s_abort_global();
		cmd(32'h06000000, 8);
		cmd(32'h39012000, 31);
		write_enable_latch(1'h1);
		rd(32'h3C012000, 1'h1);
		cmd(32'h39012000, 32);
		cmd(32'h06000000, 7);
		write_enable_latch(1'h0);
		cmd(32'h06000000, 8);
		cmd(32'h7E000000, 8);
		write_enable_latch(1'h0);
		rd(32'h3C012000, 1'h1);
	endtask
	task automatic s_range();
		@(posedge i_clk);
		i_protect_scheme_select <= 1'h0;
		rd(32'h3C012000, 1'h1);
		pe(24'h012000, 1'h1);
		i_range_protected <= 1'h1;
		pe(24'h012000, 1'h0);
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			err_total++;
			final_report();
		end
	end
	initial begin
		repeat (10) @(posedge i_clk);
		i_srst <= 1'h0;
		repeat (5) @(posedge i_clk);
		s_reset_state();
		s_lock_unlock();
		s_abort_global();
		s_range();
		final_report();
	end
endmodule
`default_nettype wire
